// [rtl/angle_sensor_sync_serial_slave.sv]
// Serial slave of the angle sensor: link framing, register access, status and CRC.
// Assumes sck idles low, select_n and sck come from the master, fault levels
// arrive asynchronously and rawAngle comes from logic on clk.
// Notes on behaviour
// - While held in fault reset, the data driver is released to high impedance and the other outputs read zero.
// - After any reset the reset-occurred status bit is set for readout.
// - Error flags hold while the error lasts, report once, then clear.
// - Undervoltage resets the device, tristates the data output and flags the reset.
// - Overvoltage tristates the output and sends no frames while it lasts.
// - An aborted transfer leaves nothing stuck; the next frame works normally.
// - Programming mode can be entered right after start-up by a command.
// - Store holds zero angle, direction, 32-point table, 112-bit customer ID.
// - Correction table spans 360 degrees in 32 points, linearly interpolated.
// - Half duplex; master starts every transfer with a read or write command.
// - Command, then data word either way, then device sends safety word.
// - Master makes the clock; device is only a slave on it.
// - Chip select is active low and driven by the master.
// - Each word acts only after all its bits are shifted in.
// - Chip select high aborts the transfer at once and resets the CRC.
// - Data changes on rising clock edges and is sampled on falling edges.
// - Transfer ends after the safety word; select then stays high a while.
// - Data driver is enabled only while the device sends bits.
// - All words go most significant bit first.
// - Select rising with no clock pulse snapshots the angle update buffer.
// - Read with access mode 11 returns the buffered snapshot.
// - Command: rw, odd parity, fixed zero, access, 7-bit address, word count.
// - Safety word: four active-low flags, sensor response nibble, checksum.
// - Checksum polynomial 0x1D over all bytes, starts all ones, sent inverted.
// - Reset-occurred flag clears once read out over the link.
`timescale 1ns/10ps
module angle_sensor_sync_serial_slave
  import angle_link_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic select_n,
  input wire logic dataIn,
  output logic dataOut_ff,
  output logic dataOe_ff,
  input wire logic [14:0] rawAngle,
  input wire logic angleInvalid,
  input wire logic underVoltage,
  input wire logic overVoltage,
  input wire logic sysFault,
  input wire logic [3:0] sensorNumberResponse,
  output logic [14:0] angleOut_ff,
  output logic progMode_ff
);

  // Link-side state
  logic [5:0] bitCnt_ff;
  logic [14:0] shift_ff;
  logic [7:0] crc_ff;
  cmd_t cmdWord_ff;
  logic [15:0] wrData_ff;
  logic cmdTgl_ff;
  logic wrTgl_ff;
  logic doneTgl_ff;
  logic pulseSeen_ff;
  logic linkAbort;
  logic seenClr;
  logic lineBit;
  logic [15:0] safeWord;

  // Core-side state
  sync_t meta_ff;
  sync_t sync_ff;
  logic selPrev_ff;
  logic cmdSeen_ff;
  logic wrSeen_ff;
  logic doneSeen_ff;
  logic clearSeen_ff;
  logic blockLink_ff;
  logic [2:0] blockHist_ff;
  logic [15:0] rdWord_ff;
  logic [7:0] safeHi_ff;
  logic cmdLegal_ff;
  logic resetFlag_ff;
  logic sysErr_ff;
  logic ifErr_ff;
  logic angleErr_ff;
  logic [14:0] angleBuf_ff;
  logic [14:0] zero_ff;
  logic dir_ff;
  logic [15:0] lut_ff [LUT_POINTS];
  logic [15:0] id_ff [ID_WORDS];

  logic devRst;
  logic quiet;
  logic cmdEvt;
  logic wrEvt;
  logic doneEvt;
  logic selRise;
  logic sysCond;
  logic legal;
  logic [15:0] rdVal;
  logic [14:0] nxt_angle;

  // Link domain

  // Select high or a fault drops the whole framing state at once
  // Select needs no sync here: it only resets flops of this domain
  assign linkAbort = select_n | blockLink_ff;
  assign seenClr = clearSeen_ff | blockLink_ff;
  assign lineBit = dataOe_ff ? dataOut_ff : dataIn;
  assign safeWord = {safeHi_ff, ~crc_ff};

  always_ff @(negedge sck or posedge linkAbort) begin
    if (linkAbort) begin
      bitCnt_ff <= 6'h00;
      shift_ff <= 15'h0000;
      crc_ff <= CRC_INIT;
    end else begin
      // Counter parks after the safety word; extra clocks do nothing
      if (bitCnt_ff != BIT_FRAME_END) begin
        bitCnt_ff <= bitCnt_ff + 6'h01;
      end
      shift_ff <= {shift_ff[13:0], dataIn};
      if (bitCnt_ff < BIT_CRC_FIRST) begin
        crc_ff <= crc_step(crc_ff, lineBit);
      end
    end
  end

  // Words handed to the core survive the end of the frame
  // Core reads them only after the toggle has passed two flops, so they are settled
  always_ff @(negedge sck or posedge blockLink_ff) begin
    if (blockLink_ff) begin
      cmdWord_ff <= cmd_t'(16'h0000);
      wrData_ff <= 16'h0000;
      cmdTgl_ff <= 1'b0;
      wrTgl_ff <= 1'b0;
      doneTgl_ff <= 1'b0;
    end else begin
      if (bitCnt_ff == BIT_CMD_LAST) begin
        cmdWord_ff <= cmd_t'({shift_ff, dataIn});
        cmdTgl_ff <= ~cmdTgl_ff;
      end
      if (bitCnt_ff == BIT_DATA_LAST && !cmdWord_ff.rw) begin
        wrData_ff <= {shift_ff, dataIn};
        wrTgl_ff <= ~wrTgl_ff;
      end
      if (bitCnt_ff == BIT_FRAME_LAST) begin
        doneTgl_ff <= ~doneTgl_ff;
      end
    end
  end

  always_ff @(posedge sck or posedge seenClr) begin
    if (seenClr) begin
      pulseSeen_ff <= 1'b0;
    end else begin
      pulseSeen_ff <= 1'b1;
    end
  end

  // Driver on only for device bits; read data relies on the master's turnaround wait
  always_ff @(posedge sck or posedge linkAbort) begin
    if (linkAbort) begin
      dataOe_ff <= 1'b0;
      dataOut_ff <= 1'b0;
    end else if (bitCnt_ff >= BIT_SAFE_FIRST && bitCnt_ff < BIT_FRAME_END) begin
      dataOe_ff <= 1'b1;
      dataOut_ff <= safeWord[~bitCnt_ff[3:0]];
    end else if (cmdWord_ff.rw && bitCnt_ff >= BIT_DATA_FIRST && bitCnt_ff <= BIT_DATA_LAST) begin
      dataOe_ff <= 1'b1;
      dataOut_ff <= rdWord_ff[~bitCnt_ff[3:0]];
    end else begin
      dataOe_ff <= 1'b0;
      dataOut_ff <= 1'b0;
    end
  end

  // Core domain

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= SYNC_RESET;
      sync_ff <= SYNC_RESET;
    end else begin
      meta_ff <= {select_n, underVoltage, overVoltage, sysFault, angleInvalid,
                  cmdTgl_ff, wrTgl_ff, doneTgl_ff, pulseSeen_ff};
      sync_ff <= meta_ff;
    end
  end

  assign devRst = !rst_n || sync_ff.uv;
  // Toggle history is meaningless for a few cycles after the link was forced down
  assign quiet = blockLink_ff | (|blockHist_ff);
  assign cmdEvt = !quiet && (sync_ff.cmdTgl != cmdSeen_ff);
  assign wrEvt = !quiet && (sync_ff.wrTgl != wrSeen_ff);
  assign doneEvt = !quiet && (sync_ff.doneTgl != doneSeen_ff);
  assign selRise = sync_ff.sel && !selPrev_ff;
  assign sysCond = sync_ff.ov | sync_ff.uv | sync_ff.sysFault;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blockLink_ff <= 1'b1;
      blockHist_ff <= 3'h7;
      cmdSeen_ff <= 1'b0;
      wrSeen_ff <= 1'b0;
      doneSeen_ff <= 1'b0;
    end else begin
      blockLink_ff <= sync_ff.uv | sync_ff.ov;
      blockHist_ff <= {blockHist_ff[1:0], blockLink_ff};
      cmdSeen_ff <= sync_ff.cmdTgl;
      wrSeen_ff <= sync_ff.wrTgl;
      doneSeen_ff <= sync_ff.doneTgl;
    end
  end

  // Snapshot of the angle update buffer on an empty select pulse
  always_ff @(posedge clk) begin
    if (devRst) begin
      selPrev_ff <= 1'b1;
      clearSeen_ff <= 1'b0;
      angleBuf_ff <= 15'h0000;
    end else begin
      selPrev_ff <= sync_ff.sel;
      clearSeen_ff <= selRise;
      if (selRise && !sync_ff.seen) begin
        angleBuf_ff <= angleOut_ff;
      end
    end
  end

  // Command check and read data
  always_comb begin
    logic isUpd;
    logic known;
    logic writable;
    isUpd = cmdWord_ff.access == ACCESS_UPDATE;
    known = 1'b1;
    writable = 1'b0;
    rdVal = 16'h0000;
    if (cmdWord_ff.addr[6:5] == ADDR_LUT_PAGE) begin
      rdVal = lut_ff[cmdWord_ff.addr[4:0]];
      writable = progMode_ff;
    end else if (cmdWord_ff.addr >= ADDR_ID_BASE && cmdWord_ff.addr <= ADDR_ID_LAST) begin
      rdVal = id_ff[3'(cmdWord_ff.addr - ADDR_ID_BASE)];
      writable = progMode_ff;
    end else begin
      unique case (cmdWord_ff.addr)
        ADDR_STATUS: rdVal = {resetFlag_ff, sysErr_ff, ifErr_ff, angleErr_ff,
                              progMode_ff, 11'h000};
        ADDR_ANGLE: rdVal = {~angleErr_ff, isUpd ? angleBuf_ff : angleOut_ff};
        ADDR_PROG: begin
          rdVal = {15'h0000, progMode_ff};
          writable = 1'b1;
        end
        ADDR_ZERO: begin
          rdVal = {1'b0, zero_ff};
          writable = progMode_ff;
        end
        ADDR_DIR: begin
          rdVal = {15'h0000, dir_ff};
          writable = progMode_ff;
        end
        default: known = 1'b0;
      endcase
    end
    // Snapshot only exists for the angle register and only for reads
    legal = (^cmdWord_ff) && !cmdWord_ff.fixed && known
            && cmdWord_ff.wordCount == WORD_COUNT_ONE
            && (cmdWord_ff.access == ACCESS_DIRECT
                || (isUpd && cmdWord_ff.rw && cmdWord_ff.addr == ADDR_ANGLE))
            && (cmdWord_ff.rw || writable);
  end

  // Per-frame answer, frozen when the command word lands
  always_ff @(posedge clk) begin
    if (devRst) begin
      rdWord_ff <= 16'h0000;
      safeHi_ff <= 8'hFF;
      cmdLegal_ff <= 1'b0;
    end else if (cmdEvt) begin
      rdWord_ff <= (legal && cmdWord_ff.rw) ? rdVal : 16'h0000;
      cmdLegal_ff <= legal;
      safeHi_ff <= {~resetFlag_ff, ~(sysErr_ff | sysCond),
                    ~(ifErr_ff | ~legal), ~(angleErr_ff | sync_ff.angleBad),
                    sensorNumberResponse};
    end
  end

  // Status flags; a new cause in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resetFlag_ff <= 1'b1;
      sysErr_ff <= 1'b0;
      ifErr_ff <= 1'b0;
      angleErr_ff <= 1'b0;
    end else begin
      resetFlag_ff <= flag_next(resetFlag_ff, sync_ff.uv,
                                doneEvt & ~safeHi_ff[7]);
      sysErr_ff <= flag_next(sysErr_ff, sysCond, doneEvt & ~safeHi_ff[6]);
      ifErr_ff <= flag_next(ifErr_ff, cmdEvt & ~legal, doneEvt & ~safeHi_ff[5]);
      angleErr_ff <= flag_next(angleErr_ff, sync_ff.angleBad,
                               doneEvt & ~safeHi_ff[4]);
    end
  end

  // Programmable store; contents kept through undervoltage resets
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_ff <= 15'h0000;
      dir_ff <= 1'b0;
      for (int i = 0; i < LUT_POINTS; i++) begin
        lut_ff[i] <= 16'h0000;
      end
      for (int i = 0; i < ID_WORDS; i++) begin
        id_ff[i] <= 16'h0000;
      end
    end else if (wrEvt && cmdLegal_ff && !cmdWord_ff.rw) begin
      if (cmdWord_ff.addr[6:5] == ADDR_LUT_PAGE) begin
        lut_ff[cmdWord_ff.addr[4:0]] <= wrData_ff;
      end else if (cmdWord_ff.addr >= ADDR_ID_BASE && cmdWord_ff.addr <= ADDR_ID_LAST) begin
        id_ff[3'(cmdWord_ff.addr - ADDR_ID_BASE)] <= wrData_ff;
      end else if (cmdWord_ff.addr == ADDR_ZERO) begin
        zero_ff <= wrData_ff[14:0];
      end else if (cmdWord_ff.addr == ADDR_DIR) begin
        dir_ff <= wrData_ff[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (devRst) begin
      progMode_ff <= 1'b0;
    end else if (wrEvt && cmdLegal_ff && !cmdWord_ff.rw && cmdWord_ff.addr == ADDR_PROG) begin
      progMode_ff <= wrData_ff == PROG_KEY;
    end
  end

  // Angle path: direction, zero offset, then table correction
  // Table entries are signed offsets; ten low angle bits weight the next point
  // Limitation: offsets are not range-checked, a large one can wrap the angle
  function automatic logic [14:0] lut_correct(input logic [14:0] rel,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
    logic signed [16:0] diff;
    logic signed [27:0] prod;
    logic [15:0] corr;
    diff = $signed({hi[15], hi}) - $signed({lo[15], lo});
    prod = 28'(diff) * $signed({18'h00000, rel[LUT_FRAC_BITS-1:0]});
    corr = lo + prod[25:10];
    return rel + corr[14:0];
  endfunction

  always_comb begin
    logic [14:0] rot;
    logic [14:0] rel;
    logic [4:0] idx;
    rot = dir_ff ? 15'(~rawAngle + 15'h0001) : rawAngle;
    rel = rot - zero_ff;
    idx = rel[14:10];
    // Last segment wraps to the first point to close the circle
    nxt_angle = lut_correct(rel, lut_ff[idx], lut_ff[5'(idx + 5'h01)]);
  end

  always_ff @(posedge clk) begin
    if (devRst) begin
      angleOut_ff <= 15'h0000;
    end else begin
      angleOut_ff <= nxt_angle;
    end
  end

endmodule

// [rtl/angle_link_pkg.sv]
// Constants, field layouts and helpers for the angle sensor serial slave.
// Assumes a 10 MHz core clock and a master that keeps to the link timing.
package angle_link_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Bit positions within a frame, counted in falling edges of the link clock
  localparam logic [5:0] BIT_CMD_LAST = 6'h0F;
  localparam logic [5:0] BIT_DATA_FIRST = 6'h10;
  localparam logic [5:0] BIT_DATA_LAST = 6'h1F;
  localparam logic [5:0] BIT_SAFE_FIRST = 6'h20;
  localparam logic [5:0] BIT_CRC_FIRST = 6'h28;
  localparam logic [5:0] BIT_FRAME_LAST = 6'h2F;
  localparam logic [5:0] BIT_FRAME_END = 6'h30;

  localparam logic [1:0] ACCESS_DIRECT = 2'h0;
  localparam logic [1:0] ACCESS_UPDATE = 2'h3;
  localparam logic [3:0] WORD_COUNT_ONE = 4'h1;

  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // Register map
  localparam logic [6:0] ADDR_STATUS = 7'h00;
  localparam logic [6:0] ADDR_ANGLE = 7'h01;
  localparam logic [6:0] ADDR_PROG = 7'h08;
  localparam logic [6:0] ADDR_ZERO = 7'h09;
  localparam logic [6:0] ADDR_DIR = 7'h0A;
  localparam logic [6:0] ADDR_ID_BASE = 7'h10;
  localparam logic [6:0] ADDR_ID_LAST = 7'h16;
  localparam logic [1:0] ADDR_LUT_PAGE = 2'h1;

  localparam int LUT_POINTS = 32;
  localparam int ID_WORDS = 7;
  localparam int LUT_FRAC_BITS = 10;

  // Key that opens programming mode; value is arbitrary
  localparam logic [15:0] PROG_KEY = 16'hA5C3;

  typedef struct packed {
    logic rw;
    logic parity;
    logic fixed;
    logic [1:0] access;
    logic [6:0] addr;
    logic [3:0] wordCount;
  } cmd_t;

  typedef struct packed {
    logic sel;
    logic uv;
    logic ov;
    logic sysFault;
    logic angleBad;
    logic cmdTgl;
    logic wrTgl;
    logic doneTgl;
    logic seen;
  } sync_t;

  localparam sync_t SYNC_RESET = sync_t'(9'h100);

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  function automatic logic flag_next(input logic cur, input logic cond, input logic rep);
    return cond | (cur & ~rep);
  endfunction

endpackage

// [verification/angle_sensor_sync_serial_slave_asserts.sv]
// Checker for the angle sensor serial slave, bound to its top module.
// Assumes sck idles low between frames of 48 pulses.
`timescale 1ns/10ps
module angle_sensor_sync_serial_slave_asserts
  import angle_link_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic select_n,
  input wire logic dataIn,
  input wire logic dataOut_ff,
  input wire logic dataOe_ff,
  input wire logic [14:0] rawAngle,
  input wire logic angleInvalid,
  input wire logic underVoltage,
  input wire logic overVoltage,
  input wire logic sysFault,
  input wire logic [3:0] sensorNumberResponse,
  input wire logic [14:0] angleOut_ff,
  input wire logic progMode_ff
);
  logic [5:0] fallCount_ff;
  logic [15:0] cmdBits_ff;
  // Saturates so stray pulses never wrap into a new frame
  always_ff @(negedge sck or posedge select_n) begin
    if (select_n) begin
      fallCount_ff <= 6'h00;
    end else if (fallCount_ff != 6'h3F) begin
      fallCount_ff <= fallCount_ff + 6'h01;
    end
  end
  always_ff @(negedge sck) begin
    if (fallCount_ff < BIT_DATA_FIRST) begin
      cmdBits_ff <= {cmdBits_ff[14:0], dataIn};
    end
  end
  property p_sel_off;
    @(posedge clk) disable iff (!rst_n) select_n && $past(select_n) |-> !dataOe_ff;
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("driver on while deselected");
  // Reset itself is the cause here, so no disable
  property p_rst_off;
    @(posedge clk) !rst_n && !$past(rst_n) |-> !dataOe_ff && !dataOut_ff && !progMode_ff;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("outputs active in reset");
  property p_uv_off;
    @(posedge clk) disable iff (!rst_n) underVoltage [*4] |-> !dataOe_ff;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("driver on in undervoltage");
  property p_ov_off;
    @(posedge clk) disable iff (!rst_n) overVoltage [*4] |-> !dataOe_ff;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("driver on in overvoltage");
  property p_oe_window;
    @(negedge sck) disable iff (!rst_n || select_n)
      dataOe_ff |-> fallCount_ff >= BIT_DATA_FIRST && fallCount_ff <= BIT_FRAME_LAST;
  endproperty
  a_oe_window: assert property (p_oe_window)
    else $error("driver on outside send bits");
  property p_safety_on;
    @(negedge sck) disable iff (!rst_n || select_n)
      fallCount_ff >= BIT_SAFE_FIRST && fallCount_ff <= BIT_FRAME_LAST && !overVoltage
      && !underVoltage |-> dataOe_ff;
  endproperty
  a_safety_on: assert property (p_safety_on)
    else $error("safety word not driven");
  property p_read_on;
    @(negedge sck) disable iff (!rst_n || select_n)
      fallCount_ff >= BIT_DATA_FIRST && fallCount_ff <= BIT_DATA_LAST && cmdBits_ff[15]
      && !overVoltage && !underVoltage |-> dataOe_ff;
  endproperty
  a_read_on: assert property (p_read_on)
    else $error("read data not driven");
  property p_write_quiet;
    @(negedge sck) disable iff (!rst_n || select_n)
      fallCount_ff >= BIT_DATA_FIRST && fallCount_ff <= BIT_DATA_LAST && !cmdBits_ff[15]
      |-> !dataOe_ff;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("driver on during write data");
  property p_sensor_number_response;
    @(negedge sck) disable iff (!rst_n || select_n)
      fallCount_ff >= 6'h24 && fallCount_ff <= 6'h27 && dataOe_ff
      |-> dataOut_ff == sensorNumberResponse[2'(6'h27 - fallCount_ff)];
  endproperty
  a_sensor_number_response: assert property (p_sensor_number_response)
    else $error("response nibble wrong");
  c_read: cover property (@(negedge sck) fallCount_ff == BIT_FRAME_LAST && cmdBits_ff[15]);
  c_write: cover property (@(negedge sck) fallCount_ff == BIT_FRAME_LAST && !cmdBits_ff[15]);
  c_ov: cover property (@(posedge clk) overVoltage && !select_n);
endmodule
bind angle_sensor_sync_serial_slave angle_sensor_sync_serial_slave_asserts
  angle_sensor_sync_serial_slave_asserts_inst (.clk(clk), .rst_n(rst_n), .sck(sck),
  .select_n(select_n), .dataIn(dataIn), .dataOut_ff(dataOut_ff), .dataOe_ff(dataOe_ff),
  .rawAngle(rawAngle), .angleInvalid(angleInvalid), .underVoltage(underVoltage),
  .overVoltage(overVoltage), .sysFault(sysFault), .sensorNumberResponse(sensorNumberResponse),
  .angleOut_ff(angleOut_ff), .progMode_ff(progMode_ff));

// [verification/link_master_model.sv]
// Serial bus master model: makes sck and select, drives command and write data.
// Assumes the bench resolves the data line from the device's enable.
`timescale 1ns/10ps
module link_master_model (
  output logic sck,
  output logic select_n,
  output logic masterData,
  input wire logic dataLine
);
  initial begin
    sck = 1'b0;
    select_n = 1'b1;
    masterData = 1'b0;
  end
  task automatic frame(input logic [15:0] cmd, input logic [15:0] wdata, input int pulses,
      output logic [15:0] rdata, output logic [15:0] safe);
    rdata = 16'h0000;
    safe = 16'h0000;
    select_n = 1'b0;
    #200;
    for (int i = 0; i < pulses; i++) begin
      if ((i == 16 && cmd[15]) || i == 32) begin
        #800;
      end
      sck = 1'b1;
      if (i < 16) begin
        masterData = cmd[15 - i];
      end else if (i < 32 && !cmd[15]) begin
        masterData = wdata[31 - i];
      end else begin
        masterData = ~masterData; // Released line, never a stale level
      end
      #40;
      sck = 1'b0;
      if (i >= 16 && i < 32) begin
        rdata[31 - i] = dataLine;
      end else if (i >= 32 && i < 48) begin
        safe[47 - i] = dataLine;
      end
      #40;
    end
    select_n = 1'b1;
    #1000;
  endtask
  task automatic snap();
    select_n = 1'b0;
    #400;
    select_n = 1'b1;
    #1000;
  endtask
endmodule

// [verification/angle_sensor_sync_serial_slave_bench.sv]
// Self-checking bench for the angle sensor serial slave.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/10ps
module angle_sensor_sync_serial_slave_bench;
  import angle_link_pkg::*;
  logic clk, rst_n, sck, select_n, dataIn, masterData, dataOut_ff, dataOe_ff, oeSeen;
  logic angleInvalid, underVoltage, overVoltage, sysFault, progMode_ff;
  logic [14:0] rawAngle, angleOut_ff, snapAngle;
  logic [3:0] sensorNumberResponse, fm;
  logic [15:0] rdata, safe, rdAngle;
  logic [15:0] bads[6];
  int bad_count, compares, zeroAngle, dirFlag;
  assign dataIn = dataOe_ff ? dataOut_ff : masterData;
  angle_sensor_sync_serial_slave angle_sensor_sync_serial_slave_inst (.clk(clk), .rst_n(rst_n),
    .sck(sck), .select_n(select_n), .dataIn(dataIn), .dataOut_ff(dataOut_ff),
    .dataOe_ff(dataOe_ff), .rawAngle(rawAngle), .angleInvalid(angleInvalid),
    .underVoltage(underVoltage), .overVoltage(overVoltage), .sysFault(sysFault),
    .sensorNumberResponse(sensorNumberResponse), .angleOut_ff(angleOut_ff),
    .progMode_ff(progMode_ff));
  link_master_model link_master_model_inst (.sck(sck), .select_n(select_n),
    .masterData(masterData), .dataLine(dataIn));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (dataOe_ff !== 1'b0) oeSeen <= 1'b1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc_model(input logic [39:0] bits);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 39; i >= 0; i--) c = (c[7] ^ bits[i]) ? {c[6:0], 1'b0} ^ 8'h1D : {c[6:0], 1'b0};
    return ~c;
  endfunction
  function automatic logic [15:0] mk(input logic rw, input logic [1:0] acc, input logic [6:0] a);
    logic [15:0] c;
    c = {rw, 2'b00, acc, a, WORD_COUNT_ONE};
    c[14] = ~^c;
    return c;
  endfunction
  function automatic logic [15:0] model_angle();
    int v;
    v = dirFlag ? -int'(rawAngle) : int'(rawAngle);
    return {1'b1, 15'(v - zeroAngle)};
  endfunction
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, input logic [3:0] flags,
      input logic [3:0] mask, input logic chkData, input logic [15:0] expData);
    link_master_model_inst.frame(cmd, wd, 48, rdata, safe);
    if (chkData) chk(rdata, expData);
    chk({12'h000, safe[15:12] & mask}, {12'h000, flags & mask});
    chk({12'h000, safe[11:8]}, {12'h000, sensorNumberResponse});
    chk({8'h00, safe[7:0]}, {8'h00, crc_model({cmd, cmd[15] ? rdata : wd, safe[15:8]})});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {rst_n, angleInvalid, underVoltage, overVoltage, sysFault, oeSeen} = 6'h00;
    {bad_count, compares, zeroAngle, dirFlag} = '0;
    rawAngle = 15'h0000;
    void'($urandom(32'h62A5));
    sensorNumberResponse = 4'($urandom());
    rdAngle = mk(1'b1, ACCESS_DIRECT, ADDR_ANGLE);
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    xfer(mk(1'b1, ACCESS_DIRECT, ADDR_STATUS), 16'h0000, 4'h7, 4'hF, 1'b0, 16'h0000);
    @(negedge clk);
    rawAngle = 15'($urandom());
    xfer(rdAngle, 16'h0000, 4'hF, 4'hF, 1'b1, model_angle());
    $display("test reset flag done");
    snapAngle = 15'($urandom());
    rawAngle = snapAngle;
    repeat (4) @(negedge clk);
    link_master_model_inst.snap();
    @(negedge clk);
    rawAngle = ~snapAngle;
    xfer(mk(1'b1, ACCESS_UPDATE, ADDR_ANGLE), 16'h0000, 4'hF, 4'hF, 1'b1, {1'b1, snapAngle});
    xfer(rdAngle, 16'h0000, 4'hF, 4'hF, 1'b1, model_angle());
    $display("test snapshot done");
    bads = '{rdAngle ^ 16'h4000, rdAngle ^ 16'h6000, rdAngle ^ 16'h0003,
      mk(1'b1, ACCESS_DIRECT, 7'h7F), mk(1'b1, 2'h1, ADDR_ANGLE), rdAngle ^ 16'hC000};
    foreach (bads[i]) xfer(bads[i], 16'h1234, 4'hD, 4'hF, bads[i][15], 16'h0000);
    link_master_model_inst.frame(rdAngle, 16'h0000, 10, rdata, safe);
    xfer(rdAngle, 16'h0000, 4'hF, 4'hF, 1'b1, model_angle());
    $display("test refusal and abort done");
    for (int j = 0; j < 2; j++) begin
      @(negedge clk);
      if (j == 0) sysFault = 1'b1;
      else angleInvalid = 1'b1;
      fm = (j == 0) ? 4'hB : 4'hE;
      repeat (2) xfer(mk(1'b1, ACCESS_DIRECT, ADDR_STATUS), 16'h0000, fm, 4'hF, 1'b0, 16'h0000);
      @(negedge clk);
      {sysFault, angleInvalid} = 2'b00;
      xfer(mk(1'b1, ACCESS_DIRECT, ADDR_STATUS), 16'h0000, fm, 4'hF, 1'b0, 16'h0000);
      xfer(mk(1'b1, ACCESS_DIRECT, ADDR_STATUS), 16'h0000, 4'hF, 4'hF, 1'b0, 16'h0000);
    end
    $display("test fault flags done");
    xfer(mk(1'b0, ACCESS_DIRECT, ADDR_ZERO), 16'h0100, 4'hD, 4'hF, 1'b0, 16'h0000);
    xfer(mk(1'b0, ACCESS_DIRECT, ADDR_PROG), PROG_KEY, 4'hF, 4'hF, 1'b0, 16'h0000);
    chk({15'h0000, progMode_ff}, 16'h0001);
    zeroAngle = $urandom() & 32'h7FFF;
    dirFlag = 1;
    xfer(mk(1'b0, ACCESS_DIRECT, ADDR_ZERO), 16'(zeroAngle), 4'hF, 4'hF, 1'b0, 16'h0000);
    xfer(mk(1'b0, ACCESS_DIRECT, ADDR_DIR), 16'h0001, 4'hF, 4'hF, 1'b0, 16'h0000);
    @(negedge clk);
    rawAngle = 15'($urandom());
    xfer(rdAngle, 16'h0000, 4'hF, 4'hF, 1'b1, model_angle());
    chk({1'b1, angleOut_ff}, model_angle());
    xfer(mk(1'b0, ACCESS_DIRECT, 7'h20), 16'h0010, 4'hF, 4'hF, 1'b0, 16'h0000);
    xfer(mk(1'b0, ACCESS_DIRECT, 7'h21), 16'h0030, 4'hF, 4'hF, 1'b0, 16'h0000);
    @(negedge clk);
    rawAngle = 15'(-(zeroAngle + 32'h200));
    repeat (3) @(negedge clk);
    chk({1'b0, angleOut_ff}, 16'h0220);
    xfer(mk(1'b0, ACCESS_DIRECT, 7'h20), 16'h0000, 4'hF, 4'hF, 1'b0, 16'h0000);
    xfer(mk(1'b0, ACCESS_DIRECT, 7'h21), 16'h0000, 4'hF, 4'hF, 1'b0, 16'h0000);
    xfer(mk(1'b0, ACCESS_DIRECT, ADDR_PROG), 16'h0000, 4'hF, 4'hF, 1'b0, 16'h0000);
    chk({15'h0000, progMode_ff}, 16'h0000);
    $display("test programming done");
    for (int j = 0; j < 2; j++) begin
      @(negedge clk);
      if (j == 0) overVoltage = 1'b1;
      else underVoltage = 1'b1;
      repeat (6) @(negedge clk);
      oeSeen = 1'b0;
      link_master_model_inst.frame(rdAngle, 16'h0000, 48, rdata, safe);
      chk({15'h0000, oeSeen}, 16'h0000);
      @(negedge clk);
      {overVoltage, underVoltage} = 2'b00;
      repeat (20) @(negedge clk);
    end
    xfer(rdAngle, 16'h0000, 4'h7, 4'h8, 1'b1, model_angle());
    $display("test supply faults done");
    give_verdict();
  end
endmodule
